//--- hw/synth_output_mode_registers.sv
// What this block does
// - Divide zero mutes outputs; one passes undivided
// - Even divides; odd rounds down; clamp 62
// - Master enable with chip enable powers oscillator
// - External oscillator buffer to output stage
// - Synthesizer buffer enable for internal oscillator
// - First output buffer enable
// - Second output buffer enable
// - External oscillator input enable
// - Pre-lock mute holds outputs until lock
// - First single-ended drives negative pin only
// - Second single-ended drives negative pin only
// - Charge pump to output a or b
// - Exact mode seed sets output phase
// - Otherwise seed reloads per auto-seed setting
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module synth_output_mode_registers
  import synth_out_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Device status inputs (pins)
  input  wire logic        chip_enable_i,
  input  wire logic        lock_i,
  input  wire logic        freq_change_i,
  // Divider and gain controls
  output logic      [5:0]  divide_ratio_o,
  output logic             undivided_frequency_o,
  output logic      [1:0]  first_out_gain_o,
  output logic      [1:0]  second_out_gain_o,
  output logic             divider_gain_max_o,
  // Subsystem enables
  output logic             osc_subsys_en_o,
  output logic             osc_en_o,
  output logic             ext_osc_buf_en_o,
  output logic             synth_buf_en_o,
  output logic             ext_input_en_o,
  // Output pin enables
  output logic             first_out_pos_en_o,
  output logic             first_out_neg_en_o,
  output logic             second_out_pos_en_o,
  output logic             second_out_neg_en_o,
  // Charge pump routing
  output logic             pump_out_a_en_o,
  output logic             pump_out_b_en_o,
  // Bias and calibration words
  output logic      [18:0] bias_trim_o,
  output logic      [1:0]  ext_input_bias_o,
  output logic      [23:0] calibration_o,
  // Modulator seed
  output logic      [23:0] phase_seed_o,
  output logic             seed_load_o
);
  logic [23:0] divgain_r;
  logic [23:0] modes_r;
  logic [23:0] bias_r;
  logic [23:0] cal_r;
  logic [23:0] seed_r;
  logic [23:0] ctl_r;
  logic [1:0]  ce_sync_r;
  logic [1:0]  lock_sync_r;
  logic [1:0]  fchg_sync_r;
  logic        fchg_d_r;
  logic        master_d_r;
  logic [31:0] prdata_r;
  logic        seed_load_r;

  wire logic [9:0] word_addr = paddr_i[11:2];
  wire logic       addr_ok   = (paddr_i[1:0] == 2'b00);
  wire logic       sel_dg  = addr_ok && (word_addr == 10'(IDX_OUTPUT_DIVIDE_GAIN));
  wire logic       sel_md  = addr_ok && (word_addr == 10'(IDX_OPERATING_MODES));
  wire logic       sel_bs  = addr_ok && (word_addr == 10'(IDX_BIAS_SETTING));
  wire logic       sel_cw  = addr_ok && (word_addr == 10'(IDX_CALIBRATION_WORD));
  wire logic       sel_sd  = addr_ok && (word_addr == 10'(IDX_MODULATOR_PHASE_SEED));
  wire logic       sel_ct  = addr_ok && (word_addr == 10'(IDX_CONTROL));
  wire logic       hit     = sel_dg | sel_md | sel_bs | sel_cw | sel_sd | sel_ct;
  wire logic       access  = psel_i && penable_i;
  wire logic       wr      = access && pwrite_i && hit;
  wire logic       rd_set  = psel_i && !penable_i && !pwrite_i;

  // Byte-lane merge over the 24 used bits
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [23:0] r;
    r = old;
    if (s[0]) r[7:0]   = d[7:0];
    if (s[1]) r[15:8]  = d[15:8];
    if (s[2]) r[23:16] = d[23:16];
    return r;
  endfunction

  wire logic [23:0] rd_mux =
    sel_dg ? divgain_r :
    sel_md ? modes_r :
    sel_bs ? bias_r :
    sel_cw ? cal_r :
    sel_sd ? seed_r :
    sel_ct ? ctl_r : 24'h00_0000;

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !hit;
  assign prdata_o  = prdata_r;

  // Full words stored, spare bits included
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      divgain_r <= RST_OUTPUT_DIVIDE_GAIN;
      modes_r   <= RST_OPERATING_MODES;
      bias_r    <= RST_BIAS_SETTING;
      cal_r     <= RST_CALIBRATION_WORD;
      seed_r    <= RST_MODULATOR_PHASE_SEED;
      ctl_r     <= RST_CONTROL;
    end else if (wr) begin
      if (sel_dg) divgain_r <= merge(divgain_r, pwdata_i, pstrb_i);
      if (sel_md) modes_r   <= merge(modes_r, pwdata_i, pstrb_i);
      if (sel_bs) bias_r    <= merge(bias_r, pwdata_i, pstrb_i);
      if (sel_cw) cal_r     <= merge(cal_r, pwdata_i, pstrb_i);
      if (sel_sd) seed_r    <= merge(seed_r, pwdata_i, pstrb_i);
      if (sel_ct) ctl_r     <= merge(ctl_r, pwdata_i, pstrb_i);
    end
  end

  // Read data captured in setup so it is stable for the access edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_set) begin
      prdata_r <= {8'h00, rd_mux};
    end
  end

  wire logic ce      = ce_sync_r[1];
  wire logic locked  = lock_sync_r[1];
  wire logic fchg_pe = fchg_sync_r[1] && !fchg_d_r;
  wire logic exact   = ctl_r[CTL_EXACT_BIT];
  wire logic autoseed = ctl_r[CTL_AUTOSEED_BIT];
  wire logic start_pe = osc_subsys_en_o && !master_d_r;
  // Seed loads at start-up always, and on every frequency change unless auto-seed is set without exact mode
  wire logic seed_load_nxt = start_pe || (fchg_pe && (exact || !autoseed));

  // Pin inputs synchronised before use
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ce_sync_r   <= 2'b00;
      lock_sync_r <= 2'b00;
      fchg_sync_r <= 2'b00;
      fchg_d_r    <= 1'b0;
      master_d_r  <= 1'b0;
      seed_load_r <= 1'b0;
    end else begin
      ce_sync_r   <= {ce_sync_r[0], chip_enable_i};
      lock_sync_r <= {lock_sync_r[0], lock_i};
      fchg_sync_r <= {fchg_sync_r[0], freq_change_i};
      fchg_d_r    <= fchg_sync_r[1];
      master_d_r  <= osc_subsys_en_o;
      seed_load_r <= seed_load_nxt;
    end
  end

  logic [5:0] ratio;
  logic       div_mute;
  logic       div_bypass;

  divide_decode u_div (
    .field_i  (divgain_r[DIV_LSB +: DIV_W]),
    .ratio_o  (ratio),
    .mute_o   (div_mute),
    .bypass_o (div_bypass)
  );

  // Pre-lock mute only gates output buffers; oscillator stays up
  wire logic pre_mute = modes_r[PRELOCK_BIT] && !locked;
  wire logic out_ok   = osc_subsys_en_o && !div_mute && !pre_mute;
  wire logic out1_on  = out_ok && modes_r[OUT1_EN_BIT];
  wire logic out2_on  = out_ok && modes_r[OUT2_EN_BIT];

  assign divide_ratio_o        = ratio;
  assign undivided_frequency_o = div_bypass;
  assign first_out_gain_o      = divgain_r[GAIN1_LSB +: 2];
  assign second_out_gain_o     = divgain_r[GAIN2_LSB +: 2];
  assign divider_gain_max_o    = divgain_r[DIVGAIN_BIT];
  assign osc_subsys_en_o       = modes_r[MASTER_EN_BIT] && ce;
  assign osc_en_o              = osc_subsys_en_o && modes_r[OSC_EN_BIT];
  assign ext_osc_buf_en_o      = osc_subsys_en_o && modes_r[EXT_BUF_BIT];
  assign synth_buf_en_o        = osc_subsys_en_o && modes_r[SYN_BUF_BIT];
  assign ext_input_en_o        = osc_subsys_en_o && modes_r[EXT_IN_BIT];
  assign first_out_neg_en_o    = out1_on;
  assign first_out_pos_en_o    = out1_on && !modes_r[SE1_BIT];
  // Single-ended only exists on the negative pin, so that reading is taken
  assign second_out_neg_en_o   = out2_on;
  assign second_out_pos_en_o   = out2_on && !modes_r[SE2_BIT];
  assign pump_out_a_en_o       = !modes_r[PUMP_SEL_BIT];
  assign pump_out_b_en_o       = modes_r[PUMP_SEL_BIT];
  assign bias_trim_o           = bias_r[18:0];
  assign ext_input_bias_o      = bias_r[EXT_BIAS_LSB +: 2];
  assign calibration_o         = cal_r;
  assign phase_seed_o          = seed_r;
  assign seed_load_o           = seed_load_r;

  property p_mute_zero;
    @(posedge clk_i) disable iff (rst_i)
      (divgain_r[5:0] == 6'h00) |-> !first_out_neg_en_o && !second_out_neg_en_o;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("outputs on at divide zero");

  property p_ratio_even;
    @(posedge clk_i) disable iff (rst_i)
      (divgain_r[5:0] > 6'h01) |-> !divide_ratio_o[0] && divide_ratio_o <= 6'h3e
        && divide_ratio_o >= 6'h02 && (divgain_r[5:0] - divide_ratio_o) <= 6'h01
        || divgain_r[5:0] > 6'h3e;
  endproperty
  a_ratio_even: assert property (p_ratio_even) else $error("bad divide ratio");

  property p_master;
    @(posedge clk_i) disable iff (rst_i)
      !ce_sync_r[1] |-> !osc_subsys_en_o && !osc_en_o && !synth_buf_en_o
        && !first_out_neg_en_o && !second_out_neg_en_o;
  endproperty
  a_master: assert property (p_master) else $error("master enable wrong");

  property p_prelock;
    @(posedge clk_i) disable iff (rst_i)
      (modes_r[7] && !lock_sync_r[1]) |-> !first_out_neg_en_o && !second_out_neg_en_o;
  endproperty
  a_prelock: assert property (p_prelock) else $error("output before lock");

  property p_se1;
    @(posedge clk_i) disable iff (rst_i)
      modes_r[8] |-> !first_out_pos_en_o;
  endproperty
  a_se1: assert property (p_se1) else $error("first pos pin on in single-ended");

  property p_se2;
    @(posedge clk_i) disable iff (rst_i)
      second_out_pos_en_o |-> second_out_neg_en_o && !modes_r[9];
  endproperty
  a_se2: assert property (p_se2) else $error("second pos pin misdriven");

  property p_pump;
    @(posedge clk_i) disable iff (rst_i)
      pump_out_a_en_o != pump_out_b_en_o;
  endproperty
  a_pump: assert property (p_pump) else $error("pump routing overlap");

  property p_writeback;
    @(posedge clk_i) disable iff (rst_i)
      (wr && sel_dg && pstrb_i == 4'hf) |=> divgain_r == 24'($past(pwdata_i));
  endproperty
  a_writeback: assert property (p_writeback) else $error("write not stored");

  property p_seed;
    @(posedge clk_i) disable iff (rst_i)
      (fchg_pe && !ctl_r[1]) |=> seed_load_o;
  endproperty
  a_seed: assert property (p_seed) else $error("seed not reloaded");
endmodule // synth_output_mode_registers

//--- hw/synth_out_pkg.sv
package synth_out_pkg;
  localparam int unsigned DATA_W = 24;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_OUTPUT_DIVIDE_GAIN   = 8'h16;
  localparam logic [7:0] IDX_OPERATING_MODES      = 8'h17;
  localparam logic [7:0] IDX_BIAS_SETTING         = 8'h18;
  localparam logic [7:0] IDX_CALIBRATION_WORD     = 8'h19;
  localparam logic [7:0] IDX_MODULATOR_PHASE_SEED = 8'h1a;
  localparam logic [7:0] IDX_CONTROL              = 8'h1b;

  localparam logic [23:0] RST_OUTPUT_DIVIDE_GAIN   = 24'h00_06c1;
  localparam logic [23:0] RST_OPERATING_MODES      = 24'h00_01ab;
  localparam logic [23:0] RST_BIAS_SETTING         = 24'h00_54c1;
  localparam logic [23:0] RST_CALIBRATION_WORD     = 24'h00_0aaa;
  localparam logic [23:0] RST_MODULATOR_PHASE_SEED = 24'hb2_9d0b;
  localparam logic [23:0] RST_CONTROL              = 24'h00_0000;

  // Field positions
  localparam int unsigned DIV_LSB        = 0;
  localparam int unsigned DIV_W          = 6;
  localparam int unsigned GAIN1_LSB      = 6;
  localparam int unsigned GAIN2_LSB      = 8;
  localparam int unsigned DIVGAIN_BIT    = 10;
  localparam int unsigned MASTER_EN_BIT  = 0;
  localparam int unsigned OSC_EN_BIT     = 1;
  localparam int unsigned EXT_BUF_BIT    = 2;
  localparam int unsigned SYN_BUF_BIT    = 3;
  localparam int unsigned OUT1_EN_BIT    = 4;
  localparam int unsigned OUT2_EN_BIT    = 5;
  localparam int unsigned EXT_IN_BIT     = 6;
  localparam int unsigned PRELOCK_BIT    = 7;
  localparam int unsigned SE1_BIT        = 8;
  localparam int unsigned SE2_BIT        = 9;
  localparam int unsigned PUMP_SEL_BIT   = 11;
  localparam int unsigned EXT_BIAS_LSB   = 19;
  localparam int unsigned CTL_EXACT_BIT  = 0;
  localparam int unsigned CTL_AUTOSEED_BIT = 1;

  localparam logic [5:0] DIV_MUTE      = 6'h00;
  localparam logic [5:0] DIV_BYPASS    = 6'h01;
  localparam logic [5:0] DIV_MAX       = 6'h3e;
endpackage

//--- hw/divide_decode.sv
`timescale 1ns/1ps
module divide_decode
  import synth_out_pkg::*;
(
  // Raw field
  input  wire logic [5:0] field_i,
  // Decoded ratio
  output logic      [5:0] ratio_o,
  output logic            mute_o,
  output logic            bypass_o
);
  wire logic [5:0] clipped = (field_i > DIV_MAX) ? DIV_MAX : field_i;

  assign mute_o   = (field_i == DIV_MUTE);
  assign bypass_o = (field_i == DIV_BYPASS);
  // Odd values from 3 up drop to the even value below; above 62 clamps to 62
  assign ratio_o  = mute_o ? DIV_MUTE :
                    bypass_o ? DIV_BYPASS : {clipped[5:1], 1'b0};
endmodule // divide_decode

//--- verif/test_synth_output_mode_registers.sv
`timescale 1ns/1ps
module test_synth_output_mode_registers
  import synth_out_pkg::*;
;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, st, v, q;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, chip_enable_i, lock_i, freq_change_i, e;
  logic [5:0]  divide_ratio_o;
  logic [1:0]  first_out_gain_o, second_out_gain_o, ext_input_bias_o;
  logic        undivided_frequency_o, divider_gain_max_o, osc_subsys_en_o, osc_en_o;
  logic        ext_osc_buf_en_o, synth_buf_en_o, ext_input_en_o, seed_load_o;
  logic        first_out_pos_en_o, first_out_neg_en_o, second_out_pos_en_o;
  logic        second_out_neg_en_o, pump_out_a_en_o, pump_out_b_en_o;
  logic [18:0] bias_trim_o;
  logic [23:0] calibration_o, phase_seed_o;
  logic [23:0] m [6];
  int          errors, check_count;
  logic [31:0] c;

  synth_output_mode_registers dut (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .chip_enable_i, .lock_i, .freq_change_i,
    .divide_ratio_o, .undivided_frequency_o, .first_out_gain_o, .second_out_gain_o,
    .divider_gain_max_o, .osc_subsys_en_o, .osc_en_o, .ext_osc_buf_en_o,
    .synth_buf_en_o, .ext_input_en_o, .first_out_pos_en_o, .first_out_neg_en_o,
    .second_out_pos_en_o, .second_out_neg_en_o, .pump_out_a_en_o, .pump_out_b_en_o,
    .bias_trim_o, .ext_input_bias_o, .calibration_o, .phase_seed_o, .seed_load_o
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  function automatic logic [11:0] ad(int i);
    return {2'b00, IDX_OUTPUT_DIVIDE_GAIN + 8'(i), 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Master side holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int n;
    @(posedge clk_i);
    pstrb_i <= s;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    chk("pready", pready_o, 1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(int i, logic [23:0] d, logic [3:0] sb = 4'hf);
    apb(1'b1, ad(i), {rnd() & 32'hff00_0000} | {8'h00, d}, sb);
    // Lane 3 has no stored bits, so its strobe is ignored
    for (int j = 0; j < 3; j++) if (sb[j]) m[i][8*j +: 8] = d[8*j +: 8];
    chk("wr_err", e, 0);
  endtask

  task automatic rd(int i);
    apb(1'b0, ad(i), 32'h0000_0000);
    chk("rd_data", q, {8'h00, m[i]});
    chk("rd_err", e, 0);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic check_all();
    logic       s, a1, a2;
    logic [5:0] d;
    s = m[1][0] & chip_enable_i;
    d = m[0][5:0];
    a1 = s & m[1][4] & (~m[1][7] | lock_i) & (d != 6'h00);
    a2 = s & m[1][5] & (~m[1][7] | lock_i) & (d != 6'h00);
    chk("ratio", divide_ratio_o, d < 2 ? d : {d[5:1], 1'b0});
    chk("undiv", undivided_frequency_o, d == 6'h01);
    chk("gains", {first_out_gain_o, second_out_gain_o, divider_gain_max_o},
        {m[0][7:6], m[0][9:8], m[0][10]});
    chk("subsys", osc_subsys_en_o, s);
    chk("enables", {osc_en_o, ext_osc_buf_en_o, synth_buf_en_o, ext_input_en_o},
        {4{s}} & {m[1][1], m[1][2], m[1][3], m[1][6]});
    chk("out1", {first_out_pos_en_o, first_out_neg_en_o}, {a1 & ~m[1][8], a1});
    chk("out2", {second_out_pos_en_o, second_out_neg_en_o}, {a2 & ~m[1][9], a2});
    chk("pump", {pump_out_a_en_o, pump_out_b_en_o}, {~m[1][11], m[1][11]});
    chk("bias", {ext_input_bias_o, bias_trim_o}, m[2][20:0]);
    chk("cal", calibration_o, m[3]);
    chk("seed", phase_seed_o, m[4]);
    @(posedge clk_i);
  endtask

  task automatic count_loads();
    c = 0;
    repeat (8) begin
      @(posedge clk_i);
      #1;
      c += {31'd0, seed_load_o};
    end
  endtask

  initial begin
    #1_000_000;
    errors++;
    final_report();
  end

  initial begin
    st = 32'h0000_0018;
    errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, chip_enable_i, lock_i, freq_change_i} = '0;
    paddr_i = '0;
    pwdata_i = '0;
    pstrb_i = 4'hf;
    m = '{RST_OUTPUT_DIVIDE_GAIN, RST_OPERATING_MODES, RST_BIAS_SETTING,
          RST_CALIBRATION_WORD, RST_MODULATOR_PHASE_SEED, RST_CONTROL};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(i);
    settle();
    check_all();
    $display("test reset values done");
    chip_enable_i <= 1'b1;
    lock_i <= 1'b1;
    for (int d = 0; d < 64; d++) begin
      v = rnd();
      wr(0, {v[23:6], 6'(d)});
      settle();
      check_all();
    end
    $display("test divide sweep done");
    // Random modes with random pin levels reach every enable path
    repeat (48) begin
      v = rnd();
      chip_enable_i <= v[31];
      lock_i <= v[30];
      for (int i = 0; i < 5; i++) begin
        v = rnd();
        wr(i, v[23:0], v[27:24]);
      end
      settle();
      check_all();
      for (int i = 0; i < 5; i++) rd(i);
    end
    $display("test random modes done");
    wr(2, 24'h18_54c3);
    wr(3, 24'h00_0ab2);
    settle();
    check_all();
    apb(1'b1, 12'h070, rnd());
    chk("unmapped_wr_err", e, 1);
    apb(1'b0, 12'h070, 32'h0000_0000);
    chk("unmapped_rd_err", e, 1);
    chk("unmapped_rd", q, 0);
    apb(1'b1, 12'h059, rnd());
    chk("misaligned_err", e, 1);
    for (int i = 0; i < 6; i++) rd(i);
    $display("test refused access done");
    chip_enable_i <= 1'b0;
    wr(1, 24'h00_01ab);
    settle();
    @(posedge clk_i);
    chip_enable_i <= 1'b1;
    count_loads();
    chk("load_on_enable", c, 1);
    // Exact mode, auto seed, neither: reload expected on change except auto seed
    for (int k = 0; k < 3; k++) begin
      wr(5, k == 0 ? 24'h00_0001 : (k == 1 ? 24'h00_0002 : 24'h00_0000));
      settle();
      @(posedge clk_i);
      freq_change_i <= 1'b1;
      count_loads();
      chk("load_on_change", c, k == 1 ? 0 : 1);
      @(posedge clk_i);
      freq_change_i <= 1'b0;
      settle();
    end
    $display("test seed reload done");
    // Mid-run reset must bring every register back to its reset value
    @(posedge clk_i);
    rst_i <= 1'b1;
    m = '{RST_OUTPUT_DIVIDE_GAIN, RST_OPERATING_MODES, RST_BIAS_SETTING,
          RST_CALIBRATION_WORD, RST_MODULATOR_PHASE_SEED, RST_CONTROL};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(i);
    settle();
    check_all();
    $display("test mid-run reset done");
    final_report();
  end
endmodule // test_synth_output_mode_registers
